//--- include/icache_defs.svh
`ifndef ICACHE_DEFS_SVH
`define ICACHE_DEFS_SVH

// ****************************************
// Control register fields
// ****************************************
`define CCR_ENABLE_BIT    0
`define CCR_FREEZE_BIT    1
`define CCR_CLR_ENTRY_BIT 2
`define CCR_CLR_ALL_BIT   3
`define CCR_RESET_VAL     2'h0

// ****************************************
// Address fields
// ****************************************
`define IDX_LSB   2
`define IDX_MSB   7
`define TAG_LSB   8
`define TAG_MSB   31
`define WORD_SEL  1
`define ENTRIES   64

`endif

//--- include/icache_pkg.sv
package icache_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOOK = 2'b01,
    ST_FILL = 2'b10
  } fetch_state_e;

  typedef logic [24:0] tag_t;
endpackage

//--- rtl/icache_ram.sv
module icache_ram #(
  parameter int DEPTH = 64,
  parameter int WIDTH = 57,
  parameter int AW    = 6
) (
  // Clock
  input  wire logic             clk,
  // Write port
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  // Read port
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule

//--- rtl/icache.sv
`include "icache_defs.svh"

// What this block does
// (R1) Direct-mapped array of 64 entries, one long word each.
// (R2) Entry holds tag A31-A8 plus space-code top bit, valid, 32 data bits.
// (R3) Fetch with cache enabled indexes an entry by A7-A2 first.
// (R4) Hit needs equal tag, equal space bit and set valid; A1 picks word.
// (R5) Miss or invalid fetches externally, fills and validates unless frozen.
// (R6) Fills are aligned long-word fetches updating both words.
// (R7) Only instruction prefetches use the cache; data accesses never do.
// (R8) Tag compare uses all address bits 31 to 8 internally.
// (R9) Reset clears all valid flags and the enable and freeze controls.
// (R10) Active-low disable input forces cache disabled regardless of enable.
// (R11) Control register 32 bits, supervisor move only; bits 31-4 read zero.
// (R12) Clear-all write clears every valid flag; reads back zero.
// (R13) Clear-entry clears valid at address register index; reads zero.
// (R14) Freeze set stops miss replacement; freeze clear lets miss fill.
// (R15) Clearing enable keeps entries; they hit again when re-enabled.
// (R16) Software writes zeros to reserved control register bits.
// (R17) Disable input invalidates nothing; entries usable after negation.
// (R18) Address register 32 bits, index in bits 7-2, rest reserved.
// (R19) Control bits: 3 clear-all, 2 clear-entry, 1 freeze, 0 enable.
// (R20) Disabled cache treats every fetch as external miss, no allocation.
module icache
  import icache_pkg::*;
#(
  parameter int ENTRIES = `ENTRIES
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // Disable pin
  input  wire logic        lookup_inhibit_n,
  // Control register move port
  input  wire logic        ctl_wr,
  input  wire logic        ctl_rd,
  input  wire logic        ctl_sel_addr,
  input  wire logic        ctl_supervisor,
  input  wire logic [31:0] ctl_wdata,
  output logic      [31:0] ctl_rdata,
  // Core prefetch port
  input  wire logic        req_valid,
  input  wire logic        req_instr,
  input  wire logic [31:0] req_addr,
  input  wire logic        space_code_top_bit,
  output logic             req_ready,
  output logic             rsp_valid,
  output logic      [15:0] rsp_word,
  output logic             rsp_hit,
  // External fetch port
  output logic             ext_req,
  output logic      [31:0] ext_addr,
  output logic             ext_cacheable,
  input  wire logic        ext_ack,
  input  wire logic [31:0] ext_data
);
  localparam int AW = $clog2(ENTRIES);
  localparam int TW = 25;

  // ****************************************
  // Pin synchroniser
  // ****************************************
  logic inh_s1_r, inh_s2_r;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      inh_s1_r <= 1'b1;
      inh_s2_r <= 1'b1;
    end else begin
      inh_s1_r <= lookup_inhibit_n;
      inh_s2_r <= inh_s1_r;
    end
  end

  // ****************************************
  // Control and address registers
  // ****************************************
  logic          en_r, en_nxt, frz_r, frz_nxt;
  logic [AW-1:0] cache_addr_reg_idx_r, cache_addr_reg_idx_nxt;
  logic [ENTRIES-1:0] valid_r, valid_nxt;
  logic          ctl_wr_ok, cache_on;

  assign ctl_wr_ok = ctl_wr && ctl_supervisor;                 // see (R11)
  assign cache_on  = en_r && inh_s2_r;                         // see (R10)

  always_comb begin
    en_nxt       = en_r;
    frz_nxt      = frz_r;
    cache_addr_reg_idx_nxt = cache_addr_reg_idx_r;
    if (ctl_wr_ok && !ctl_sel_addr) begin
      en_nxt  = ctl_wdata[`CCR_ENABLE_BIT];                    // see (R19)
      frz_nxt = ctl_wdata[`CCR_FREEZE_BIT];
    end
    if (ctl_wr_ok && ctl_sel_addr) begin
      cache_addr_reg_idx_nxt = ctl_wdata[`IDX_MSB:`IDX_LSB];             // see (R18)
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      en_r       <= 1'b0;                                      // see (R9)
      frz_r      <= 1'b0;
      cache_addr_reg_idx_r <= '0;
    end else begin
      en_r       <= en_nxt;
      frz_r      <= frz_nxt;
      cache_addr_reg_idx_r <= cache_addr_reg_idx_nxt;
    end
  end

  // Reserved and clear bits read zero
  always_comb begin
    ctl_rdata = 32'h0000_0000;                                 // see (R11)
    if (ctl_rd && ctl_supervisor) begin
      if (ctl_sel_addr) begin
        ctl_rdata[`IDX_MSB:`IDX_LSB] = cache_addr_reg_idx_r;
      end else begin
        ctl_rdata[`CCR_ENABLE_BIT] = en_r;                     // see (R12)
        ctl_rdata[`CCR_FREEZE_BIT] = frz_r;                    // see (R13)
      end
    end
  end

  // ****************************************
  // Fetch sequencer
  // ****************************************
  fetch_state_e  st_r, st_nxt;
  logic [31:0]   addr_r, addr_nxt;
  logic          fc_r, fc_nxt, use_r, use_nxt;
  logic [15:0]   word_r, word_nxt;
  logic          rv_r, rv_nxt, hit_r, hit_nxt;
  logic [TW+32-1:0] rd_data;
  logic          tag_eq, hit, fill_we;

  function automatic tag_t make_tag(input logic [31:0] a, input logic fc);
    make_tag = {fc, a[`TAG_MSB:`TAG_LSB]};                     // see (R8)
  endfunction

  function automatic logic [AW-1:0] idx_of(input logic [31:0] a);
    idx_of = a[`IDX_MSB:`IDX_LSB];                             // see (R3)
  endfunction

  icache_ram #(.DEPTH(ENTRIES), .WIDTH(TW + 32), .AW(AW)) u_ram ( // see (R1)
    .clk     (clk),
    .wr_en   (fill_we),
    .wr_addr (idx_of(addr_r)),
    .wr_data ({make_tag(addr_r, fc_r), ext_data}),             // see (R2)
    .rd_addr (idx_of(req_addr)),
    .rd_data (rd_data)
  );

  assign tag_eq = rd_data[TW+31:32] == make_tag(addr_r, fc_r);
  assign hit    = use_r && cache_on && valid_r[idx_of(addr_r)]
                  && tag_eq;                                   // see (R4)
  assign fill_we = (st_r == ST_FILL) && ext_ack && use_r
                   && cache_on && !frz_r;                      // see (R14)

  always_comb begin
    st_nxt   = st_r;
    addr_nxt = addr_r;
    fc_nxt   = fc_r;
    use_nxt  = use_r;
    word_nxt = word_r;
    rv_nxt   = 1'b0;
    hit_nxt  = 1'b0;
    unique case (st_r)
      ST_IDLE: begin
        if (req_valid) begin
          addr_nxt = req_addr;
          fc_nxt   = space_code_top_bit;
          use_nxt  = req_instr && cache_on;                    // see (R7)
          st_nxt   = ST_LOOK;
        end
      end
      ST_LOOK: begin
        if (hit) begin
          word_nxt = addr_r[`WORD_SEL] ? rd_data[15:0] : rd_data[31:16];
          rv_nxt   = 1'b1;
          hit_nxt  = 1'b1;
          st_nxt   = ST_IDLE;
        end else begin
          st_nxt = ST_FILL;                                    // see (R20)
        end
      end
      ST_FILL: begin
        if (ext_ack) begin
          word_nxt = addr_r[`WORD_SEL] ? ext_data[15:0] : ext_data[31:16];
          rv_nxt   = 1'b1;
          st_nxt   = ST_IDLE;
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r   <= ST_IDLE;
      addr_r <= 32'h0000_0000;
      fc_r   <= 1'b0;
      use_r  <= 1'b0;
      word_r <= 16'h0000;
      rv_r   <= 1'b0;
      hit_r  <= 1'b0;
    end else begin
      st_r   <= st_nxt;
      addr_r <= addr_nxt;
      fc_r   <= fc_nxt;
      use_r  <= use_nxt;
      word_r <= word_nxt;
      rv_r   <= rv_nxt;
      hit_r  <= hit_nxt;
    end
  end

  // ****************************************
  // Valid flags
  // ****************************************
  always_comb begin
    valid_nxt = valid_r;                                 // see (R15) (R17)
    if (fill_we) begin
      valid_nxt[idx_of(addr_r)] = 1'b1;                        // see (R5)
    end
    if (ctl_wr_ok && !ctl_sel_addr && ctl_wdata[`CCR_CLR_ENTRY_BIT]) begin
      valid_nxt[cache_addr_reg_idx_r] = 1'b0;                            // see (R13)
    end
    if (ctl_wr_ok && !ctl_sel_addr && ctl_wdata[`CCR_CLR_ALL_BIT]) begin
      valid_nxt = '0;                                          // see (R12)
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      valid_r <= '0;                                           // see (R9)
    end else begin
      valid_r <= valid_nxt;
    end
  end

  assign req_ready     = (st_r == ST_IDLE);
  assign rsp_valid     = rv_r;
  assign rsp_word      = word_r;
  assign rsp_hit       = hit_r;
  assign ext_req       = (st_r == ST_FILL);
  assign ext_addr      = {addr_r[31:2], 2'b00};                // see (R6)
  assign ext_cacheable = use_r;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  reset_ctl_a: assert property ($rose(arst_n) |-> !en_r && !frz_r) // see (R9)
    else $error("controls not cleared by reset");
  inhibit_a: assert property (!inh_s2_r |=> !rsp_hit)          // see (R10)
    else $error("hit while disable pin asserted");
  data_nohit_a: assert property (                              // see (R7)
      st_r == ST_LOOK && !use_r |=> ext_req && !ext_cacheable)
    else $error("data access looked up");
  freeze_a: assert property (frz_r |-> !fill_we)               // see (R14)
    else $error("fill while frozen");
  fill_valid_a: assert property (fill_we |=>                   // see (R5)
      valid_r[idx_of($past(addr_r))] || $past(ctl_wr_ok))
    else $error("fill did not set valid");
  clr_all_a: assert property (ctl_wr_ok && !ctl_sel_addr &&    // see (R12)
      ctl_wdata[`CCR_CLR_ALL_BIT] |=> valid_r == '0)
    else $error("clear-all left valid entries");
  rd_zero_a: assert property (ctl_rdata[31:8] == 24'h00_0000 && // see (R11)
      (ctl_sel_addr ? ctl_rdata[1:0] == 2'b00
                    : ctl_rdata[7:2] == 6'h00))
    else $error("reserved bits read nonzero");
  ext_align_a: assert property (ext_req |-> ext_addr[1:0] == 2'b00) // see (R6)
    else $error("misaligned fill");
  miss_ext_a: assert property (                                // see (R20)
      st_r == ST_LOOK && !hit |=> ext_req)
    else $error("miss not sent outside");
  disabled_a: assert property (                                // see (R20)
      !cache_on && st_r == ST_LOOK |=> !rsp_hit)
    else $error("hit with cache off");

  hit_c:    cover property (rsp_valid && rsp_hit);
  miss_c:   cover property (fill_we);
  frz_c:    cover property (frz_r && ext_ack && ext_req);
  clr_e_c:  cover property (ctl_wr_ok && ctl_wdata[2] && !ctl_sel_addr);
endmodule

//--- tb/ext_mem_model.sv
// ********************************
// Far-side memory for line fills
// ********************************
module ext_mem_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // Pacing: low answers at once, high after four cycles
  input  wire logic        slow,
  // Fetch port
  input  wire logic        ext_req,
  input  wire logic [31:0] ext_addr,
  output logic             ext_ack,
  output logic      [31:0] ext_data
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [2:0] wait_r;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wait_r   <= 3'h0;
      ext_ack  <= 1'h0;
      ext_data <= 32'h0;
    end else begin
      ext_ack  <= 1'h0;
      // Stale data must never look valid
      ext_data <= ~ext_data;
      if (ext_req && !ext_ack) begin
        wait_r <= wait_r + 3'h1;
        if (!slow || wait_r == 3'h3) begin
          wait_r   <= 3'h0;
          ext_ack  <= 1'h1;
          ext_data <= {ext_addr[31:2], 2'h0} ^ 32'h5A5A_0F0F;
        end
      end
    end
  end
endmodule

//--- tb/icache_bench.sv
module icache_bench;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [1:0]  op;
    logic [1:0]  fl;
    logic [31:0] a;
    logic [31:0] d;
  } row_s;

  localparam logic [1:0]  W = 2'h0;
  localparam logic [1:0]  R = 2'h1;
  localparam logic [1:0]  F = 2'h2;
  localparam logic [31:0] A = 32'h0001_2344;
  localparam logic [31:0] B = 32'h0001_2244;
  localparam logic [31:0] C = 32'h0001_2348;

  logic        clk, arst_n, lookup_inhibit_n, ctl_wr, ctl_rd;
  logic        ctl_sel_addr, ctl_supervisor, req_valid, req_instr;
  logic        space_code_top_bit, req_ready, rsp_valid, rsp_hit;
  logic        ext_req, ext_ack, slow, ext_cacheable;
  logic [31:0] ctl_wdata, ctl_rdata, req_addr, ext_addr, ext_data;
  logic [15:0] rsp_word;
  int          errors, cmp_count, cyc;

  // ********************************
  // Design and far side
  // ********************************
  icache i_dut (.clk(clk), .arst_n(arst_n),
    .lookup_inhibit_n(lookup_inhibit_n), .ctl_wr(ctl_wr),
    .ctl_rd(ctl_rd), .ctl_sel_addr(ctl_sel_addr),
    .ctl_supervisor(ctl_supervisor), .ctl_wdata(ctl_wdata),
    .ctl_rdata(ctl_rdata), .req_valid(req_valid),
    .req_instr(req_instr), .req_addr(req_addr),
    .space_code_top_bit(space_code_top_bit), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_word(rsp_word), .rsp_hit(rsp_hit),
    .ext_req(ext_req), .ext_addr(ext_addr),
    .ext_cacheable(ext_cacheable),
    .ext_ack(ext_ack), .ext_data(ext_data));
  ext_mem_model i_mem (.clk(clk), .arst_n(arst_n), .slow(slow),
    .ext_req(ext_req), .ext_addr(ext_addr), .ext_ack(ext_ack),
    .ext_data(ext_data));

  always #2 clk = ~clk;

  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      conclude();
    end
  end

  always @(negedge clk)
    if (ext_req === 1'h1 && ext_ack === 1'h1)
      chk(32'(ext_addr[1:0]), 32'h0);

  // ********************************
  // Shared tasks
  // ********************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic sel, input logic [31:0] d, input logic sup);
    ctl_wr = 1'h1;
    ctl_sel_addr = sel;
    ctl_wdata = d;
    ctl_supervisor = sup;
    @(negedge clk);
    ctl_wr = 1'h0;
    ctl_supervisor = 1'h1;
  endtask

  task automatic rd(input logic sel, input logic [31:0] e);
    ctl_rd = 1'h1;
    ctl_sel_addr = sel;
    #1 chk(ctl_rdata, e);
    @(negedge clk);
    ctl_rd = 1'h0;
  endtask

  task automatic fetch(input logic [31:0] a, input logic [1:0] fl,
                       input logic hit, input logic cach);
    logic [31:0] d;
    int n;
    logic seen;
    d = {a[31:2], 2'h0} ^ 32'h5A5A_0F0F;
    n = 0;
    seen = 1'h0;
    req_valid = 1'h1;
    req_addr = a;
    space_code_top_bit = fl[1];
    req_instr = fl[0];
    @(negedge clk);
    req_valid = 1'h0;
    while (rsp_valid !== 1'h1 && n < 40) begin
      @(negedge clk);
      n++;
      if (ext_req === 1'h1 && !seen) begin
        seen = 1'h1;
        chk(32'(ext_cacheable), 32'(cach));
      end
    end
    chk(32'(seen), 32'(!hit));
    chk(32'(rsp_hit), 32'(hit));
    chk(32'(a[1] ? d[15:0] : d[31:16]), 32'(rsp_word));
  endtask

  task automatic conclude;
    $display("Compares %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Fetch rows: bit 0 of d is the hit, bit 1 the expected cacheable flag
  row_s rows [] = '{
    '{R, 2'h0, A, 32'h0},
    '{W, 2'h1, A, 32'h0000_0001},
    '{R, 2'h0, A, 32'h1},
    '{W, 2'h0, A, 32'h0},
    '{R, 2'h0, A, 32'h1},
    '{F, 2'h1, A, 32'h2},
    '{F, 2'h1, A, 32'h1},
    '{F, 2'h1, A | 32'h2, 32'h1},
    '{F, 2'h1, A ^ 32'hFF00_0000, 32'h2},
    '{F, 2'h1, A, 32'h2},
    '{F, 2'h3, A, 32'h2},
    '{F, 2'h1, A, 32'h2},
    '{F, 2'h0, A, 32'h0},
    '{F, 2'h1, A, 32'h1},
    '{W, 2'h1, A, 32'h3},
    '{F, 2'h1, B, 32'h2},
    '{F, 2'h1, B, 32'h2},
    '{F, 2'h1, A, 32'h1},
    '{R, 2'h0, A, 32'h3},
    '{W, 2'h1, A, 32'h0},
    '{F, 2'h1, B, 32'h0},
    '{W, 2'h1, A, 32'h1},
    '{F, 2'h1, A, 32'h1},
    '{F, 2'h1, C, 32'h2},
    '{W, 2'h3, A, A},
    '{R, 2'h2, A, A & 32'hFC},
    '{W, 2'h1, A, 32'h5},
    '{R, 2'h0, A, 32'h1},
    '{F, 2'h1, A, 32'h2},
    '{F, 2'h1, C, 32'h1},
    '{W, 2'h1, A, 32'h9},
    '{R, 2'h0, A, 32'h1},
    '{F, 2'h1, C, 32'h2}
  };

  // ********************************
  // Main sequence
  // ********************************
  initial begin
    {clk, arst_n, ctl_wr, ctl_rd, ctl_sel_addr, slow} = 6'h0;
    {req_valid, req_instr, space_code_top_bit} = 3'h0;
    {lookup_inhibit_n, ctl_supervisor} = 2'h3;
    ctl_wdata = 32'h0;
    req_addr = 32'h0;
    repeat (2) @(negedge clk);
    arst_n = 1'h1;
    foreach (rows[i]) begin
      slow = i[0];
      case (rows[i].op)
        W: wr(rows[i].fl[1], rows[i].d, rows[i].fl[0]);
        R: rd(rows[i].fl[1], rows[i].d);
        default: fetch(rows[i].a, rows[i].fl, rows[i].d[0], rows[i].d[1]);
      endcase
      $display("Row %0d done", i);
    end
    lookup_inhibit_n = 1'h0;
    repeat (3) @(negedge clk);
    fetch(C, 2'h1, 1'h0, 1'h0);
    lookup_inhibit_n = 1'h1;
    repeat (3) @(negedge clk);
    fetch(C, 2'h1, 1'h1, 1'h0);
    $display("Disable pin test done");
    arst_n = 1'h0;
    repeat (2) @(negedge clk);
    arst_n = 1'h1;
    rd(1'h0, 32'h0);
    wr(1'h0, 32'h1, 1'h1);
    fetch(C, 2'h1, 1'h0, 1'h1);
    $display("Reset test done");
    conclude();
  end
endmodule
